// [bench/dblc_top_sva.sv]
// Port assertions for the loop bandwidth and limit configuration block.
`timescale 1ns/10ps
module dblc_top_sva (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [7:0]  host_wdata,
    input wire logic [7:0]  host_rdata,
    input wire logic        host_rd_valid,
    input wire logic        loop_locked,
    input wire logic        freq_at_limit,
    input wire logic        use_acquisition_bw,
    input wire logic        freeze_integral,
    input wire logic [15:0] nominal_frequency
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    AST_ACQ_CAUSE: assert property (use_acquisition_bw |-> !$past(loop_locked))
        else $error("acquisition bandwidth while locked");
    AST_ACQ_OFF: assert property (host_wr && host_addr == 8'h3B && !host_wdata[7]
        |-> ##2 !use_acquisition_bw) else $error("acquisition bandwidth with pick off");
    AST_FRZ_ON: assert property (host_wr && host_addr == 8'h3B && host_wdata[3] ##1
        !host_wr && freq_at_limit |=> freeze_integral) else $error("no freeze at limit");
    AST_FRZ_CAUSE: assert property (freeze_integral |-> $past(freq_at_limit))
        else $error("freeze away from limit");
    AST_FRZ_OFF: assert property (host_wr && host_addr == 8'h3B && !host_wdata[3]
        |-> ##2 !freeze_integral) else $error("freeze with limit disabled");
    AST_RD_BACK: assert property ((host_wr && host_addr == 8'h3B ##1 host_rd &&
        !host_wr && host_addr == 8'h3B) |=> host_rd_valid && host_rdata == $past(host_wdata, 2))
        else $error("select register read back wrong");
    AST_CAL_LOW: assert property (host_wr && host_addr == 8'h3C
        |=> nominal_frequency[7:0] == $past(host_wdata)) else $error("low byte not stored");
    AST_CAL_HIGH: assert property (host_wr && host_addr == 8'h3D
        |=> nominal_frequency[15:8] == $past(host_wdata)) else $error("high byte not stored");
endmodule : dblc_top_sva
bind dblc_top dblc_top_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rd_valid(host_rd_valid), .loop_locked(loop_locked),
    .freq_at_limit(freq_at_limit), .use_acquisition_bw(use_acquisition_bw),
    .freeze_integral(freeze_integral), .nominal_frequency(nominal_frequency));

// [bench/tb.sv]
// Self-checking bench for the loop bandwidth and limit configuration block.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  host_addr = 8'h00, host_wdata = 8'h00, host_rdata;
    logic        host_wr = 1'b0, host_rd = 1'b0, host_rd_valid;
    logic        loop_locked = 1'b0, freq_at_limit = 1'b0, use_acquisition_bw, freeze_integral;
    logic [15:0] nominal_frequency;
    int          err_count = 0, n_checks = 0, cycles = 0;
    always #10 sys_clk = ~sys_clk;
    dblc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rd_valid(host_rd_valid), .loop_locked(loop_locked), .freq_at_limit(freq_at_limit),
        .use_acquisition_bw(use_acquisition_bw), .freeze_integral(freeze_integral),
        .nominal_frequency(nominal_frequency));
    task automatic test_done;
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic cyc(input logic w, r, input logic [7:0] a, d);
        @(posedge sys_clk);
        host_wr    <= w;
        host_rd    <= r;
        host_addr  <= a;
        host_wdata <= d;
    endtask : cyc
    task automatic settle;
        cyc(1'b0, 1'b0, 8'h00, 8'h00);
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle
    task automatic rd(input logic [7:0] a, e);
        cyc(1'b0, 1'b1, a, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge sys_clk);
        `CHK(host_rd_valid, 1'b1)
        `CHK(host_rdata, e)
        @(negedge sys_clk);
        `CHK(host_rd_valid, 1'b0)
        `CHK(host_rdata, e)
    endtask : rd
    task automatic pol(input logic [7:0] c, input logic lk, lim, ea, ef);
        cyc(1'b1, 1'b0, 8'h3B, c);
        loop_locked   <= lk;
        freq_at_limit <= lim;
        settle;
        `CHK(use_acquisition_bw, ea)
        `CHK(freeze_integral, ef)
    endtask : pol
    task automatic t_reset;
        rd(8'h3B, 8'hFB);
        rd(8'h3C, 8'h99);
        rd(8'h3D, 8'h99);
        `CHK(nominal_frequency, 16'h9999)
    endtask : t_reset
    task automatic t_rw;
        cyc(1'b1, 1'b0, 8'h3C, 8'h5A);
        cyc(1'b1, 1'b0, 8'h3D, 8'hA5);
        rd(8'h3D, 8'hA5);
        `CHK(nominal_frequency, 16'hA55A)
        cyc(1'b1, 1'b0, 8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        rd(8'h3C, 8'h5A);
        cyc(1'b1, 1'b0, 8'h3B, 8'h00);
        rd(8'h3B, 8'h00);
    endtask : t_rw
    task automatic t_pol;
        pol(8'h80, 1'b0, 1'b1, 1'b1, 1'b0);
        pol(8'h80, 1'b1, 1'b1, 1'b0, 1'b0);
        pol(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        pol(8'h08, 1'b0, 1'b1, 1'b0, 1'b1);
        pol(8'h08, 1'b0, 1'b0, 1'b0, 1'b0);
        pol(8'hFB, 1'b0, 1'b1, 1'b1, 1'b1);
    endtask : t_pol
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_rw;
        t_pol;
        test_done;
    end
endmodule : tb

// [src/dblc_ctrl_if.sv]
// Carrier between the register bank and the loop policy module.
`timescale 1ns/10ps
interface dblc_ctrl_if;
    logic automatic_bandwidth_pick;
    logic integral_freeze_at_limit;
    logic loop_locked;
    logic freq_at_limit;
    logic use_acquisition_bw;
    logic freeze_integral;

    modport cfg (
        output automatic_bandwidth_pick,
        output integral_freeze_at_limit,
        output loop_locked,
        output freq_at_limit,
        input  use_acquisition_bw,
        input  freeze_integral
    );
    modport policy (
        input  automatic_bandwidth_pick,
        input  integral_freeze_at_limit,
        input  loop_locked,
        input  freq_at_limit,
        output use_acquisition_bw,
        output freeze_integral
    );
endinterface : dblc_ctrl_if

// [src/dblc_loop_policy.sv]
// Turns the configuration bits and loop state into bandwidth and freeze controls.
`timescale 1ns/10ps
module dblc_loop_policy (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    reset_n,
    // Configuration and loop state
    dblc_ctrl_if.policy ctrl
);

    typedef struct packed {
        logic use_acquisition_bw;
        logic freeze_integral;
    } dblc_policy_state_t;

    dblc_policy_state_t state_reg;
    dblc_policy_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // Acquisition bandwidth only while automatic picking is on and not locked.
        state_next.use_acquisition_bw = ctrl.automatic_bandwidth_pick
                                        & ~ctrl.loop_locked;
        // A set bit freezes the integral path once the loop sits at a limit.
        state_next.freeze_integral = ctrl.integral_freeze_at_limit
                                     & ctrl.freq_at_limit;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ctrl.use_acquisition_bw = state_reg.use_acquisition_bw;
    assign ctrl.freeze_integral    = state_reg.freeze_integral;

endmodule : dblc_loop_policy

// [src/dblc_pkg.sv]
// Constants shared by the loop bandwidth and limit configuration block.
package dblc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LOOP_BANDWIDTH_SELECT_OFS      = 8'h3B;
    localparam logic [7:0] OSCILLATOR_CALIBRATION_LOW_OFS = 8'h3C;
    localparam logic [7:0] OSCILLATOR_CALIBRATION_HIGH_OFS = 8'h3D;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LOOP_BANDWIDTH_SELECT_RST       = 8'hFB;
    localparam logic [7:0] OSCILLATOR_CALIBRATION_LOW_RST  = 8'h99;
    localparam logic [7:0] OSCILLATOR_CALIBRATION_HIGH_RST = 8'h99;

    // ------------------------------------------------------------------
    // Field positions and bus answers
    // ------------------------------------------------------------------
    localparam int         AUTOMATIC_BANDWIDTH_PICK_BIT = 7;
    localparam int         INTEGRAL_FREEZE_AT_LIMIT_BIT = 3;
    localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

endpackage : dblc_pkg

// [src/dblc_top.sv]
// Register bank for loop bandwidth selection, integral limit and oscillator calibration.
`timescale 1ns/10ps
module dblc_top (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Microprocessor port
    input  wire logic [7:0] host_addr,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    output logic            host_rd_valid,
    // Loop state from the locked loop
    input  wire logic       loop_locked,
    input  wire logic       freq_at_limit,
    // Controls to the locked loop
    output logic            use_acquisition_bw,
    output logic            freeze_integral,
    output logic      [15:0] nominal_frequency
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] loop_bandwidth_select;
        logic [7:0] calibration_low;
        logic [7:0] calibration_high;
        logic [7:0] rdata;
        logic       rd_valid;
    } dblc_state_t;

    dblc_state_t state_reg;
    dblc_state_t state_next;

    dblc_ctrl_if ctrl ();

    function automatic logic dblc_hit(input logic [7:0] addr, input logic [7:0] ofs);
        dblc_hit = (addr == ofs);
    endfunction : dblc_hit

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    always_comb begin
        state_next          = state_reg;
        state_next.rd_valid = host_rd;
        if (host_wr) begin
            if (dblc_hit(host_addr, dblc_pkg::LOOP_BANDWIDTH_SELECT_OFS)) begin
                state_next.loop_bandwidth_select = host_wdata;
            end
            if (dblc_hit(host_addr, dblc_pkg::OSCILLATOR_CALIBRATION_LOW_OFS)) begin
                state_next.calibration_low = host_wdata;
            end
            if (dblc_hit(host_addr, dblc_pkg::OSCILLATOR_CALIBRATION_HIGH_OFS)) begin
                state_next.calibration_high = host_wdata;
            end
        end
        if (host_rd) begin
            if (dblc_hit(host_addr, dblc_pkg::LOOP_BANDWIDTH_SELECT_OFS)) begin
                state_next.rdata = state_reg.loop_bandwidth_select;
            end else if (dblc_hit(host_addr, dblc_pkg::OSCILLATOR_CALIBRATION_LOW_OFS)) begin
                state_next.rdata = state_reg.calibration_low;
            end else if (dblc_hit(host_addr, dblc_pkg::OSCILLATOR_CALIBRATION_HIGH_OFS)) begin
                state_next.rdata = state_reg.calibration_high;
            end else begin
                state_next.rdata = dblc_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.loop_bandwidth_select <= dblc_pkg::LOOP_BANDWIDTH_SELECT_RST;
            state_reg.calibration_low       <= dblc_pkg::OSCILLATOR_CALIBRATION_LOW_RST;
            state_reg.calibration_high      <= dblc_pkg::OSCILLATOR_CALIBRATION_HIGH_RST;
            state_reg.rdata                 <= 8'h00;
            state_reg.rd_valid              <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Loop policy
    // ------------------------------------------------------------------
    assign ctrl.automatic_bandwidth_pick =
        state_reg.loop_bandwidth_select[dblc_pkg::AUTOMATIC_BANDWIDTH_PICK_BIT];
    assign ctrl.integral_freeze_at_limit =
        state_reg.loop_bandwidth_select[dblc_pkg::INTEGRAL_FREEZE_AT_LIMIT_BIT];
    assign ctrl.loop_locked   = loop_locked;
    assign ctrl.freq_at_limit = freq_at_limit;

    dblc_loop_policy u_policy (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .ctrl    (ctrl.policy)
    );

    assign host_rdata         = state_reg.rdata;
    assign host_rd_valid      = state_reg.rd_valid;
    assign use_acquisition_bw = ctrl.use_acquisition_bw;
    assign freeze_integral    = ctrl.freeze_integral;
    assign nominal_frequency  = {state_reg.calibration_high, state_reg.calibration_low};

endmodule : dblc_top
